// [src/blu_pkg.sv]
/*
 * constants and types shared by the boolean unit and its control decoder.
 * assumes a single 250 MHz clock and a 32-bit AXI4-Lite register port.
 */
package blu_pkg;
    // ----------------------------------------
    // data widths and field positions
    // ----------------------------------------
    localparam int XW = 60;
    localparam int BW = 18;
    localparam int CW = 4;
    localparam int COEF_W = 48;
    localparam int UP_W = 12;
    localparam int EXP_W = 11;
    localparam int EXP_MAG_W = 10;
    localparam int SIGN_BIT = 59;
    localparam int EXP_SIGN_BIT = 58;
    localparam int B_EXT_W = 8;
    localparam logic [10:0] EXP_POS_MASK = 11'h400;
    localparam logic [10:0] EXP_NEG_MASK = 11'h3FF;

    // ----------------------------------------
    // opcodes as {f bit 0, m bits 2..0}; octal 10..17, 26, 27
    // ----------------------------------------
    typedef enum logic [3:0] {
        OP_UNPACK = 4'h6,
        OP_PACK = 4'h7,
        OP_XMIT_J = 4'h8,
        OP_AND = 4'h9,
        OP_OR = 4'hA,
        OP_XOR = 4'hB,
        OP_XMIT_NK = 4'hC,
        OP_ANDN = 4'hD,
        OP_ORN = 4'hE,
        OP_XORN = 4'hF
    } blu_op_t;

    // ----------------------------------------
    // register port
    // ----------------------------------------
    localparam int AW = 4;
    localparam int DW = 32;
    localparam int CNT_W = 16;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_COUNT = 4'h4;
    localparam logic [3:0] REG_LAST = 4'h8;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RESET = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [src/blu_decode.sv]
/*
 * control translator: turns the held opcode into path-select controls.
 * assumes op_code comes from a register on the same clock.
 */
`timescale 1ns/100ps
module blu_decode (
    input wire logic [blu_pkg::CW-1:0] op_code,
    input wire logic k_sign,
    output logic and_path_enable,
    output logic k_high_enable,
    output logic k_low_enable,
    output logic j_path_enable,
    output logic k_invert,
    output logic pack_path_enable,
    output logic pack_sign_sel,
    output logic extend_x,
    output logic unpack_sel,
    output logic bool_op
);
    // ----------------------------------------
    // decode
    // ----------------------------------------
    always_comb begin
        and_path_enable = 1'b0;
        k_high_enable = 1'b0;
        k_low_enable = 1'b0;
        j_path_enable = 1'b0;
        k_invert = 1'b0;
        pack_path_enable = 1'b0;
        pack_sign_sel = 1'b0;
        extend_x = 1'b0;
        unpack_sel = 1'b0;
        bool_op = 1'b1;
        case (blu_pkg::blu_op_t'(op_code))
            blu_pkg::OP_XMIT_J: begin
                j_path_enable = 1'b1;
            end
            blu_pkg::OP_AND: begin
                and_path_enable = 1'b1;
            end
            blu_pkg::OP_ANDN: begin
                and_path_enable = 1'b1;
                k_invert = 1'b1;
            end
            blu_pkg::OP_OR, blu_pkg::OP_ORN: begin
                and_path_enable = 1'b1;
                j_path_enable = 1'b1;
                k_high_enable = 1'b1;
                k_low_enable = 1'b1;
                k_invert = op_code[2];
            end
            blu_pkg::OP_XOR, blu_pkg::OP_XORN: begin
                j_path_enable = 1'b1;
                k_high_enable = 1'b1;
                k_low_enable = 1'b1;
                k_invert = op_code[2];
            end
            blu_pkg::OP_XMIT_NK: begin
                k_high_enable = 1'b1;
                k_low_enable = 1'b1;
                k_invert = 1'b1;
            end
            blu_pkg::OP_UNPACK: begin
                k_low_enable = 1'b1;
                unpack_sel = 1'b1;
                extend_x = k_sign;
            end
            blu_pkg::OP_PACK: begin
                k_low_enable = 1'b1;
                pack_path_enable = 1'b1;
                pack_sign_sel = k_sign;
            end
            default: begin
                bool_op = 1'b0;
            end
        endcase
    end
endmodule

// [src/blu_unit.sv]
/*
 * two-stage boolean functional unit with an AXI4-Lite control port.
 * assumes issue logic presents operands and opcode bits every cycle
 * and raises go_boolean one cycle after a boolean instruction issues.
 */
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
module blu_unit (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [blu_pkg::BW-1:0] b_operand_reg,
    input wire logic [blu_pkg::XW-1:0] first_operand,
    input wire logic [blu_pkg::XW-1:0] second_operand,
    input wire logic f_bit0,
    input wire logic [2:0] m_bits,
    input wire logic go_boolean,
    output logic [blu_pkg::XW-1:0] result_word_dest,
    output logic x_write_en,
    output logic [blu_pkg::BW-1:0] b_result,
    output logic b_write_en,
    input wire logic [blu_pkg::AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [blu_pkg::DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [blu_pkg::AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [blu_pkg::DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [blu_pkg::BW-1:0] b_op_q, b_result_d;
    logic [blu_pkg::XW-1:0] j_op_q, k_op_q;
    logic [blu_pkg::CW-1:0] code_q;
    logic and_path_enable, k_high_enable, k_low_enable, j_path_enable, k_invert;
    logic pack_path_enable, pack_sign_sel, extend_x, unpack_sel, bool_op;
    logic k_sign;
    logic [blu_pkg::XW-1:0] k_sel, lp_word, j_gated, k_gated, logic_word, result_d;
    logic [blu_pkg::UP_W-1:0] upper_d;
    logic [blu_pkg::EXP_W-1:0] pack_exp;
    logic [blu_pkg::EXP_MAG_W-1:0] exp_inner;
    logic exp_sign;
    logic up_logic, x_go, b_go;
    logic ctrl_en_q;
    logic [blu_pkg::CNT_W-1:0] op_count_q;
    logic [blu_pkg::CW-1:0] last_code_q;
    logic last_b_q;
    logic [blu_pkg::AW-1:0] awaddr_q;
    logic [blu_pkg::DW-1:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_hs, w_hs, ar_hs;

    assign k_sign = k_op_q[blu_pkg::SIGN_BIT];

    // ----------------------------------------
    // input registers, loaded every cycle
    // ----------------------------------------
    // no issue qualifier here: stale operands are harmless since go gates writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            b_op_q <= '0;
            j_op_q <= '0;
            k_op_q <= '0;
        end else begin
            b_op_q <= b_operand_reg;
            j_op_q <= first_operand;
            k_op_q <= second_operand;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code_q <= '0;
        end else begin
            code_q <= {f_bit0, m_bits};
        end
    end

    blu_decode u_decode (
        .op_code(code_q),
        .k_sign(k_sign),
        .and_path_enable(and_path_enable),
        .k_high_enable(k_high_enable),
        .k_low_enable(k_low_enable),
        .j_path_enable(j_path_enable),
        .k_invert(k_invert),
        .pack_path_enable(pack_path_enable),
        .pack_sign_sel(pack_sign_sel),
        .extend_x(extend_x),
        .unpack_sel(unpack_sel),
        .bool_op(bool_op)
    );

    // ----------------------------------------
    // static selection network
    // ----------------------------------------
    always_comb begin
        k_sel = k_invert ? ~k_op_q : k_op_q;
        lp_word = and_path_enable ? (j_op_q & k_sel) : '0;
        j_gated = j_path_enable ? j_op_q : '0;
        k_gated[blu_pkg::COEF_W-1:0] = k_low_enable ? k_sel[blu_pkg::COEF_W-1:0] : '0;
        k_gated[blu_pkg::XW-1:blu_pkg::COEF_W] =
            k_high_enable ? k_sel[blu_pkg::XW-1:blu_pkg::COEF_W] : '0;
        logic_word = lp_word | (j_gated ^ k_gated);
    end

    // pack: bias added by bit 10 flip; negative coefficient flips 0..9
    assign pack_exp = b_op_q[blu_pkg::EXP_W-1:0] ^
        (k_sign ? blu_pkg::EXP_NEG_MASK : blu_pkg::EXP_POS_MASK);

    // unpack: complement when positive, then recomplement on the way out
    always_comb begin
        exp_inner = k_op_q[blu_pkg::EXP_SIGN_BIT-1:blu_pkg::COEF_W];
        if (!k_sign) begin
            exp_inner = ~exp_inner;
        end
        exp_sign = ~(k_op_q[blu_pkg::EXP_SIGN_BIT] ^ k_sign);
        b_result_d = {{blu_pkg::B_EXT_W{exp_sign}}, ~exp_inner};
    end

    // upper bits are shared: exactly one of three sources is chosen
    assign up_logic = !unpack_sel && !pack_path_enable;

    always_comb begin
        if (unpack_sel) begin
            upper_d = {blu_pkg::UP_W{extend_x}};
        end else if (pack_path_enable) begin
            upper_d = {pack_sign_sel, pack_exp};
        end else begin
            upper_d = logic_word[blu_pkg::XW-1:blu_pkg::COEF_W];
        end
        result_d = {upper_d, logic_word[blu_pkg::COEF_W-1:0]};
    end

    // ----------------------------------------
    // destination stage
    // ----------------------------------------
    assign x_go = go_boolean && bool_op && ctrl_en_q;
    assign b_go = x_go && unpack_sel;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            x_write_en <= 1'b0;
            b_write_en <= 1'b0;
        end else begin
            x_write_en <= x_go;
            b_write_en <= b_go;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_word_dest <= '0;
        end else if (x_go) begin
            result_word_dest <= result_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            b_result <= '0;
        end else if (b_go) begin
            b_result <= b_result_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            op_count_q <= '0;
            last_code_q <= '0;
            last_b_q <= 1'b0;
        end else if (x_go) begin
            op_count_q <= op_count_q + 1'b1;
            last_code_q <= code_q;
            last_b_q <= unpack_sel;
        end
    end

    // ----------------------------------------
    // register port, write side
    // ----------------------------------------
    // address and data taken in either order; response after both
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            awaddr_q <= '0;
        end else if (aw_hs) begin
            s_axi_awready <= 1'b0;
            awaddr_q <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b1;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (w_hs) begin
            s_axi_wready <= 1'b0;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= blu_pkg::RESP_OKAY;
        end else if (!s_axi_bvalid && !s_axi_awready && !s_axi_wready) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q == blu_pkg::REG_CTRL) ? blu_pkg::RESP_OKAY :
                (awaddr_q == blu_pkg::REG_COUNT || awaddr_q == blu_pkg::REG_LAST) ?
                blu_pkg::RESP_OKAY : blu_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // only the enable bit is writable; count and last-op are read-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_en_q <= blu_pkg::CTRL_EN_RESET;
        end else if (!s_axi_bvalid && !s_axi_awready && !s_axi_wready &&
                     awaddr_q == blu_pkg::REG_CTRL && wstrb_q[0]) begin
            ctrl_en_q <= wdata_q[blu_pkg::CTRL_EN_BIT];
        end
    end

    // ----------------------------------------
    // register port, read side
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= blu_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= blu_pkg::RESP_OKAY;
            case (s_axi_araddr)
                blu_pkg::REG_CTRL: begin
                    s_axi_rdata <= blu_pkg::DW'(ctrl_en_q);
                end
                blu_pkg::REG_COUNT: begin
                    s_axi_rdata <= blu_pkg::DW'(op_count_q);
                end
                blu_pkg::REG_LAST: begin
                    s_axi_rdata <= blu_pkg::DW'({last_b_q, last_code_q});
                end
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= blu_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_issue;
        bool_op ##0 go_boolean ##0 ctrl_en_q;
    endsequence

    sequence s_retire;
        x_write_en ##0 result_word_dest == $past(result_d);
    endsequence

    // start only from an edge that sees reset high: the release edge still loads zeros
    chk_operand_load: assert property (
        aresetn |=> (j_op_q == $past(first_operand) && k_op_q == $past(second_operand)
            && b_op_q == $past(b_operand_reg)))
        else $error("operand registers did not reload");
    chk_code_load: assert property (
        aresetn |=> code_q == $past({f_bit0, m_bits}))
        else $error("opcode bits not registered");
    chk_two_cycle: assert property (
        s_issue |=> s_retire)
        else $error("result not written the cycle after go");
    chk_write_on_go: assert property (
        x_write_en |-> $past(go_boolean) && $past(bool_op))
        else $error("destination written without go");
    chk_idle_hold: assert property (
        !go_boolean |=> $stable(result_word_dest) && !x_write_en)
        else $error("result changed with no issue");
    chk_and_path: assert property (
        go_boolean && ctrl_en_q && code_q[2:0] inside {3'h1, 3'h5} && code_q[3]
        |=> result_word_dest == $past(j_op_q & (code_q[2] ? ~k_op_q : k_op_q)))
        else $error("wrong logical product");
    chk_or_path: assert property (
        go_boolean && ctrl_en_q && code_q[3] && code_q[1:0] == 2'h2
        |=> result_word_dest == $past(j_op_q | (code_q[2] ? ~k_op_q : k_op_q)))
        else $error("wrong logical sum");
    chk_xor_path: assert property (
        go_boolean && ctrl_en_q && code_q[3] && code_q[1:0] == 2'h3
        |=> result_word_dest == $past(j_op_q ^ (code_q[2] ? ~k_op_q : k_op_q)))
        else $error("wrong logical difference");
    chk_transmit: assert property (
        go_boolean && ctrl_en_q && code_q[3] && code_q[1:0] == 2'h0
        |=> result_word_dest == $past(code_q[2] ? ~k_op_q : j_op_q))
        else $error("wrong transmit result");
    chk_unpack_x: assert property (
        go_boolean && ctrl_en_q && code_q == blu_pkg::OP_UNPACK |=>
        result_word_dest == $past({{blu_pkg::UP_W{k_sign}},
            k_op_q[blu_pkg::COEF_W-1:0]}))
        else $error("wrong unpack coefficient");
    chk_unpack_b: assert property (
        b_write_en |-> b_result[blu_pkg::EXP_MAG_W-1:0] == $past(k_sign ?
        ~k_op_q[blu_pkg::EXP_SIGN_BIT-1:blu_pkg::COEF_W] :
        k_op_q[blu_pkg::EXP_SIGN_BIT-1:blu_pkg::COEF_W]))
        else $error("wrong unpacked exponent");
    chk_b_block: assert property (
        b_write_en |-> x_write_en && $past(code_q) == blu_pkg::OP_UNPACK)
        else $error("B written by a non-unpack op");
    chk_upper_src: assert property (
        $onehot({unpack_sel, pack_path_enable, up_logic}))
        else $error("more than one upper source");
    chk_pack_word: assert property (
        go_boolean && ctrl_en_q && code_q == blu_pkg::OP_PACK |=>
        result_word_dest[blu_pkg::SIGN_BIT] == $past(k_sign) &&
        result_word_dest[blu_pkg::EXP_SIGN_BIT] == $past(~b_op_q[blu_pkg::EXP_W-1] ^ k_sign))
        else $error("wrong packed exponent or sign");
endmodule

// [testbench/blu_issue_model.sv]
/*
 * issue-side partner: presents operands and opcode bits every cycle, raises go.
 * assumes the bench drives its request inputs by non-blocking assignment.
 */
`timescale 1ns/100ps
module blu_issue_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic issue,
    input wire logic [3:0] code,
    input wire logic [59:0] j_val,
    input wire logic [59:0] k_val,
    input wire logic [17:0] b_val,
    output logic [59:0] first_operand,
    output logic [59:0] second_operand,
    output logic [17:0] b_operand_reg,
    output logic f_bit0,
    output logic [2:0] m_bits,
    output logic go_boolean
);
    // ----------------------------------------
    // idle pattern
    // ----------------------------------------
    logic [63:0] junk_q;
    // changes every cycle so stale operands never look stable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            junk_q <= 64'h0F1E2D3C4B5A6978;
        end else begin
            junk_q <= {junk_q[62:0], junk_q[63] ^ junk_q[62] ^ junk_q[60] ^ junk_q[59]};
        end
    end
    // ----------------------------------------
    // issue bus
    // ----------------------------------------
    // designator bits go out every cycle, issued or not
    assign {f_bit0, m_bits} = issue ? code : junk_q[3:0];
    assign first_operand = issue ? j_val : junk_q[59:0];
    assign second_operand = issue ? k_val : ~junk_q[63:4];
    assign b_operand_reg = issue ? b_val : junk_q[40:23];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            go_boolean <= 1'b0;
        end else begin
            go_boolean <= issue;
        end
    end
endmodule

// [testbench/tb_top.sv]
/*
 * self-checking bench for the boolean unit: opcodes, refusals, register port.
 * assumes the design's issue timing and its AXI4-Lite register map.
 */
`timescale 1ns/100ps
module tb_top;
    typedef struct packed {logic w; logic u; logic [59:0] x; logic [17:0] b;} blu_exp_t;
    logic aclk, aresetn, issue, f_bit0, go_boolean, x_write_en, b_write_en;
    logic [3:0] code;
    logic [2:0] m_bits;
    logic [59:0] j_val, k_val, first_operand, second_operand, result_word_dest, x_hold;
    logic [17:0] b_val, b_operand_reg, b_result, b_hold;
    logic [3:0] awaddr, wstrb, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic en_exp;
    logic [4:0] last_exp;
    blu_exp_t cur, d1, d2;
    int failures = 0;
    int compares = 0;
    int cnt_exp = 0;

    blu_issue_model issue_model (.aclk(aclk), .aresetn(aresetn), .issue(issue), .code(code),
        .j_val(j_val), .k_val(k_val), .b_val(b_val), .first_operand(first_operand),
        .second_operand(second_operand), .b_operand_reg(b_operand_reg), .f_bit0(f_bit0),
        .m_bits(m_bits), .go_boolean(go_boolean));
    blu_unit dut (.aclk(aclk), .aresetn(aresetn), .b_operand_reg(b_operand_reg),
        .first_operand(first_operand), .second_operand(second_operand), .f_bit0(f_bit0),
        .m_bits(m_bits), .go_boolean(go_boolean), .result_word_dest(result_word_dest),
        .x_write_en(x_write_en), .b_result(b_result), .b_write_en(b_write_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    initial aclk = 1'b0;
    always #2 aclk = ~aclk;

    // ----------------------------------------
    // expectations and compares
    // ----------------------------------------
    function automatic logic [59:0] exp_x(input logic [3:0] c, input logic [59:0] j, k,
                                          input logic [17:0] b);
        case (c)
            blu_pkg::OP_XMIT_J: return j;
            blu_pkg::OP_AND: return j & k;
            blu_pkg::OP_OR: return j | k;
            blu_pkg::OP_XOR: return j ^ k;
            blu_pkg::OP_XMIT_NK: return ~k;
            blu_pkg::OP_ANDN: return j & ~k;
            blu_pkg::OP_ORN: return j | ~k;
            blu_pkg::OP_XORN: return j ^ ~k;
            blu_pkg::OP_UNPACK: return {{12{k[59]}}, k[47:0]};
            blu_pkg::OP_PACK: return {k[59], b[10:0] ^ (k[59] ? 11'h3FF : 11'h400), k[47:0]};
            default: return 60'h0;
        endcase
    endfunction

    function automatic logic [17:0] exp_b(input logic [59:0] k);
        logic s;
        s = ~(k[58] ^ k[59]);
        return {{8{s}}, k[57:48] ^ {10{k[59]}}};
    endfunction

    task automatic cmp_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t flag got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic cmp_data(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t data got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic timeout();
        failures++;
        $display("ERROR %0t bus wait ran out", $time);
        tally_and_finish();
    endtask

    // write enables two edges after issue, outputs held between writes
    always @(posedge aclk) begin
        if (!aresetn) begin
            d1 = '0;
            d2 = '0;
            x_hold = '0;
            b_hold = '0;
        end else begin
            cmp_flag(x_write_en, d2.w);
            cmp_flag(b_write_en, d2.w && d2.u);
            if (d2.w) x_hold = d2.x;
            if (d2.w) cnt_exp++;
            if (d2.w && d2.u) b_hold = d2.b;
            cmp_data(64'(result_word_dest), 64'(x_hold));
            cmp_data(64'(b_result), 64'(b_hold));
            d2 = d1;
            d1 = cur;
            d1.w = issue && cur.w;
        end
    end

    // ----------------------------------------
    // drivers
    // ----------------------------------------
    task automatic do_op(input logic [3:0] c, input logic s);
        logic [59:0] j, k;
        logic [17:0] b;
        j = 60'({$urandom(), $urandom()});
        k = 60'({$urandom(), $urandom()});
        k[59] = s;
        b = 18'($urandom());
        if (en_exp && c >= 4'h6) last_exp = {c == blu_pkg::OP_UNPACK, c};
        @(posedge aclk);
        issue <= 1'b1;
        code <= c;
        j_val <= j;
        k_val <= k;
        b_val <= b;
        cur <= '{en_exp && c >= 4'h6, c == blu_pkg::OP_UNPACK, exp_x(c, j, k, b), exp_b(k)};
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge aclk) issue <= 1'b0;
    endtask

    task automatic bus_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        r = bresp;
        bready <= 1'b0;
        if (bvalid !== 1'b1) timeout();
    endtask

    task automatic chk_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        if (rvalid !== 1'b1) timeout();
        cmp_data(64'(rdata), 64'(ed));
        cmp_data(64'(rresp), 64'(er));
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [1:0] r;
        {aresetn, issue, code, j_val, k_val, b_val, awvalid, wvalid, bready} = '0;
        {awaddr, wdata, wstrb, araddr, arvalid, rready} = '0;
        cur = '0;
        last_exp = '0;
        en_exp = 1'b1;
        void'($urandom(32'h16280791));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        chk_read(blu_pkg::REG_CTRL, 32'h1, blu_pkg::RESP_OKAY);
        // every opcode back to back, positive then negative coefficient
        for (int s = 0; s < 2; s++) begin
            for (int i = 6; i < 16; i++) do_op(4'(i), 1'(s));
        end
        // go with codes that are not boolean ones
        for (int i = 0; i < 6; i++) do_op(4'(i), 1'b1);
        idle(3);
        // disabled unit must not write either destination
        bus_write(blu_pkg::REG_CTRL, 32'h0, r);
        cmp_data(64'(r), 64'(blu_pkg::RESP_OKAY));
        en_exp = 1'b0;
        do_op(blu_pkg::OP_UNPACK, 1'b0);
        do_op(blu_pkg::OP_AND, 1'b1);
        idle(3);
        bus_write(blu_pkg::REG_CTRL, 32'h1, r);
        en_exp = 1'b1;
        bus_write(4'hC, 32'h1, r);
        cmp_data(64'(r), 64'(blu_pkg::RESP_SLVERR));
        chk_read(4'hC, 32'h0, blu_pkg::RESP_SLVERR);
        repeat (300) begin
            do_op(4'($urandom_range(15, 0)), 1'($urandom()));
            if ($urandom_range(3, 0) == 0) idle(1);
        end
        idle(4);
        // count is read-only: the write answers okay and leaves it alone
        bus_write(blu_pkg::REG_COUNT, 32'h0, r);
        cmp_data(64'(r), 64'(blu_pkg::RESP_OKAY));
        chk_read(blu_pkg::REG_COUNT, {16'h0, 16'(cnt_exp)}, blu_pkg::RESP_OKAY);
        chk_read(blu_pkg::REG_LAST, 32'(last_exp), blu_pkg::RESP_OKAY);
        tally_and_finish();
    end
endmodule
